/* File: hw/bus_transceiver.sv */
// octal registered bus transceiver with apb control and capture readout
// assumes pins sampled on pclk; far side obeys the one-driver-per-bus rule
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module bus_transceiver
    import xcvr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_a_to_b,
    input wire logic clk_b_to_a,
    input wire logic [xcvr_pkg::DATA_W-1:0] port_a_in,
    output logic [xcvr_pkg::DATA_W-1:0] port_a_out,
    output logic port_a_oe_n,
    input wire logic [xcvr_pkg::DATA_W-1:0] port_b_in,
    output logic [xcvr_pkg::DATA_W-1:0] port_b_out,
    output logic port_b_oe_n
);
    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [3:0] ctrl_q;
    logic output_enable_n;
    logic transfer_way;
    logic source_sel_a_to_b;
    logic source_sel_b_to_a;
    logic wr_en;
    logic rd_en;

    assign output_enable_n = ctrl_q[CTRL_OE_N_BIT];
    assign transfer_way = ctrl_q[CTRL_WAY_BIT];
    assign source_sel_a_to_b = ctrl_q[CTRL_SAB_BIT];
    assign source_sel_b_to_a = ctrl_q[CTRL_SBA_BIT];
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && pready && paddr == CTRL_OFFS) begin
            ctrl_q <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // storage registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] store_ab;
    logic [DATA_W-1:0] store_ba;
    logic ab_valid;
    logic ba_valid;
    logic ab_load;
    logic ba_load;

    edge_capture u_cap_ab (
        .pclk(pclk),
        .presetn(presetn),
        .cap_clk(clk_a_to_b),
        .port_in(port_a_in),
        .stored_value(store_ab),
        .stored_valid(ab_valid),
        .load_pulse(ab_load)
    );

    edge_capture u_cap_ba (
        .pclk(pclk),
        .presetn(presetn),
        .cap_clk(clk_b_to_a),
        .port_in(port_b_in),
        .stored_value(store_ba),
        .stored_valid(ba_valid),
        .load_pulse(ba_load)
    );

    // ------------------------------------------------------------
    // output path
    // ------------------------------------------------------------
    logic drive_a;
    logic drive_b;
    logic [DATA_W-1:0] ab_src;
    logic [DATA_W-1:0] ba_src;

    assign drive_b = ~output_enable_n & transfer_way;
    assign drive_a = ~output_enable_n & ~transfer_way;
    assign ab_src = source_sel_a_to_b ? store_ab : port_a_in;
    assign ba_src = source_sel_b_to_a ? store_ba : port_b_in;

    // output is one pclk behind inputs: registered pins trade latency for timing
    // new contents pass on the same path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_out <= '0;
        end else begin
            port_b_out <= drive_b ? ab_src : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_out <= '0;
        end else begin
            port_a_out <= drive_a ? ba_src : '0;
        end
    end

    // enables held off in reset so neither bus sees a driver early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_oe_n <= 1'b1;
        end else begin
            port_b_oe_n <= ~drive_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_oe_n <= 1'b1;
        end else begin
            port_a_oe_n <= ~drive_a;
        end
    end

    // ------------------------------------------------------------
    // capture buffer: both stores pushed on any load
    // ------------------------------------------------------------
    logic buf_in_ready;
    logic buf_out_valid;
    logic [2*DATA_W-1:0] buf_out_data;
    logic buf_pop;
    logic buf_push;
    logic [DATA_W-1:0] next_ab;
    logic [DATA_W-1:0] next_ba;

    // snapshot values as they will stand after this edge
    assign next_ab = ab_load ? port_a_in : store_ab;
    assign next_ba = ba_load ? port_b_in : store_ba;
    assign buf_push = ab_load | ba_load;
    assign buf_pop = rd_en & pready & (paddr == STORE_OFFS);

    // a full buffer drops snapshots; readout lags the pins, not the reverse
    skid_buffer u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .in_data({next_ba, next_ab}),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop),
        .out_data(buf_out_data)
    );

    // ------------------------------------------------------------
    // apb slave: one wait state, answer in access cycle 2
    // ------------------------------------------------------------
    logic [31:0] rdata_d;
    logic known;

    always_comb begin
        rdata_d = 32'h0000_0000;
        known = 1'b1;
        case (paddr)
            CTRL_OFFS: rdata_d = {28'h0, ctrl_q};
            STATUS_OFFS: begin
                rdata_d[STAT_AB_VALID_BIT] = ab_valid;
                rdata_d[STAT_BA_VALID_BIT] = ba_valid;
                rdata_d[STAT_DRV_A_BIT] = ~port_a_oe_n;
                rdata_d[STAT_DRV_B_BIT] = ~port_b_oe_n;
                rdata_d[STAT_BUF_FULL_BIT] = ~buf_in_ready;
            end
            STORE_OFFS: begin
                rdata_d = {buf_out_valid, 15'h0, buf_out_data};
            end
            default: known = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= rd_en & ~pready ? rdata_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & penable & ~pready & ~known;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // released when disabled
    a_disable_releases: assert property (@(posedge pclk) disable iff (!presetn)
        output_enable_n |=> port_a_oe_n && port_b_oe_n)
        else $error("port driven while disabled");
    a_single_driver: assert property (@(posedge pclk) disable iff (!presetn)
        port_a_oe_n || port_b_oe_n)
        else $error("both ports driven");
    a_live_to_b: assert property (@(posedge pclk) disable iff (!presetn)
        drive_b && !source_sel_a_to_b |=> !port_b_oe_n
            && port_b_out == $past(port_a_in))
        else $error("port_b not following live port_a");
    a_stored_to_b: assert property (@(posedge pclk) disable iff (!presetn)
        drive_b && source_sel_a_to_b |=> port_b_out == $past(store_ab))
        else $error("port_b not showing stored value");
    a_live_to_a: assert property (@(posedge pclk) disable iff (!presetn)
        drive_a && !source_sel_b_to_a |=> !port_a_oe_n
            && port_a_out == $past(port_b_in))
        else $error("port_a not following live port_b");
    a_stored_to_a: assert property (@(posedge pclk) disable iff (!presetn)
        drive_a && source_sel_b_to_a |=> port_a_out == $past(store_ba))
        else $error("port_a not showing stored value");
    a_way_selects: assert property (@(posedge pclk) disable iff (!presetn)
        !output_enable_n |=> port_b_oe_n == !$past(transfer_way))
        else $error("transfer_way ignored");
    a_load_isolated: assert property (@(posedge pclk) disable iff (!presetn)
        output_enable_n && ab_load ##1 1 |-> store_ab == $past(port_a_in))
        else $error("isolated load lost");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");

    a_released_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (!port_a_oe_n || port_a_out == 8'h00)
            && (!port_b_oe_n || port_b_out == 8'h00))
        else $error("released port shows data");
    a_load_isolated_b: assert property (@(posedge pclk) disable iff (!presetn)
        output_enable_n && ba_load |=> store_ba == $past(port_b_in))
        else $error("isolated b-side load lost");
    a_stored_new_b: assert property (@(posedge pclk) disable iff (!presetn)
        drive_b && source_sel_a_to_b && ab_load
            ##1 drive_b && source_sel_a_to_b
            |=> port_b_out == $past(port_a_in, 2))
        else $error("port_b missed newly stored value");
    a_stored_new_a: assert property (@(posedge pclk) disable iff (!presetn)
        drive_a && source_sel_b_to_a && ba_load
            ##1 drive_a && source_sel_b_to_a
            |=> port_a_out == $past(port_b_in, 2))
        else $error("port_a missed newly stored value");

    // apb: control lands only on the answering edge
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && pready && paddr == CTRL_OFFS
            |=> ctrl_q == $past(pwdata[3:0]))
        else $error("control write lost");
    a_ctrl_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && pready && paddr == CTRL_OFFS) |=> $stable(ctrl_q))
        else $error("control changed without a write");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held past one cycle");
    a_prdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    a_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !known |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without answer");

    c_b_stored: cover property (@(posedge pclk) disable iff (!presetn)
        drive_b && source_sel_a_to_b && ab_load);
    c_a_live: cover property (@(posedge pclk) disable iff (!presetn)
        drive_a && !source_sel_b_to_a);
    c_isolated_load: cover property (@(posedge pclk) disable iff (!presetn)
        output_enable_n && ba_load);
    c_buf_full: cover property (@(posedge pclk) disable iff (!presetn)
        !buf_in_ready);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);
endmodule : bus_transceiver
`default_nettype wire

/* File: pkg/xcvr_pkg.sv */
// constants for the octal registered bus transceiver
// assumes one 250 MHz clock pclk; device pins sampled synchronous to it
package xcvr_pkg;
    localparam int DATA_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam int PTR_W = 1;
    // apb register map
    localparam logic [11:0] CTRL_OFFS = 12'h000;
    localparam logic [11:0] STATUS_OFFS = 12'h004;
    localparam logic [11:0] STORE_OFFS = 12'h008;
    // control field positions
    localparam int CTRL_OE_N_BIT = 0;
    localparam int CTRL_WAY_BIT = 1;
    localparam int CTRL_SAB_BIT = 2;
    localparam int CTRL_SBA_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h1;
    // status field positions
    localparam int STAT_AB_VALID_BIT = 0;
    localparam int STAT_BA_VALID_BIT = 1;
    localparam int STAT_DRV_A_BIT = 2;
    localparam int STAT_DRV_B_BIT = 3;
    localparam int STAT_BUF_FULL_BIT = 4;
endpackage : xcvr_pkg

/* File: hw/edge_capture.sv */
// one direction's storage register, loaded on the rising edge of its clock pin
// assumes the clock pin is a plain input sampled on pclk
`timescale 1ns/1ns
`default_nettype none
module edge_capture
    import xcvr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cap_clk,
    input wire logic [xcvr_pkg::DATA_W-1:0] port_in,
    output logic [xcvr_pkg::DATA_W-1:0] stored_value,
    output logic stored_valid,
    output logic load_pulse
);
    logic cap_clk_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_clk_q <= 1'b0;
        end else begin
            cap_clk_q <= cap_clk;
        end
    end

    assign load_pulse = cap_clk & ~cap_clk_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stored_value <= '0;
        end else if (load_pulse) begin
            stored_value <= port_in;
        end
    end

    // contents flagged invalid until first rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stored_valid <= 1'b0;
        end else if (load_pulse) begin
            stored_valid <= 1'b1;
        end
    end

    a_store_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !load_pulse |=> stored_value == $past(stored_value))
        else $error("stored value changed without a clock edge");
    a_store_loads: assert property (@(posedge pclk) disable iff (!presetn)
        load_pulse |=> stored_value == $past(port_in) && stored_valid)
        else $error("register did not load on clock edge");
endmodule : edge_capture
`default_nettype wire

/* File: hw/skid_buffer.sv */
// two-entry buffer for captured words read out over apb
// assumes the drain side may stall; push ready goes only to status, so the source never waits
`timescale 1ns/1ns
`default_nettype none
module skid_buffer
    import xcvr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [2*xcvr_pkg::DATA_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [2*xcvr_pkg::DATA_W-1:0] out_data
);
    logic [2*DATA_W-1:0] mem_q [BUF_DEPTH];
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != (PTR_W+1)'(BUF_DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    always_ff @(posedge pclk) begin
        if (push) mem_q[wr_q] <= in_data;
    end

    a_no_overflow: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q <= (PTR_W+1)'(BUF_DEPTH))
        else $error("buffer overflow");
endmodule : skid_buffer
`default_nettype wire

/* File: verif/bus_side_model.sv */
// far-side bus model: one external 8-bit bus facing the transceiver
// assumes bench drives ext_en/ext_data off pclk edges; no pull on the bus
`timescale 1ns/1ns
`default_nettype none
module bus_side_model (
    input wire logic pclk,
    input wire logic ext_en,
    input wire logic [7:0] ext_data,
    input wire logic [7:0] dev_out,
    input wire logic dev_oe_n,
    output logic [7:0] level
);
    logic [7:0] last_q;
    // ----------------------------------------
    // wire resolution
    // ----------------------------------------
    // floating bus shows a changing pattern, not a held value
    always_ff @(posedge pclk) begin
        last_q <= level;
    end
    always_comb begin
        if (!dev_oe_n) begin
            level = dev_out;
        end else if (ext_en) begin
            level = ext_data;
        end else begin
            level = ~last_q;
        end
    end
endmodule : bus_side_model
`default_nettype wire

/* File: verif/bus_transceiver_tb_top.sv */
// self-checking bench for the bus transceiver: apb control, pin traffic
// assumes one 250 MHz pclk; both far buses modelled by bus_side_model
`timescale 1ns/1ns
`default_nettype none
module bus_transceiver_tb_top;
    import xcvr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic clk_a_to_b, clk_b_to_a, er;
    logic [7:0] a_lvl, b_lvl, a_out, b_out, a_dat, b_dat;
    logic a_oe_n, b_oe_n;
    int mismatches = 0;
    int comparisons = 0;
    bus_transceiver dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_a_to_b(clk_a_to_b), .clk_b_to_a(clk_b_to_a),
        .port_a_in(a_lvl), .port_a_out(a_out), .port_a_oe_n(a_oe_n),
        .port_b_in(b_lvl), .port_b_out(b_out), .port_b_oe_n(b_oe_n));
    bus_side_model bus_a_u (.pclk(pclk), .ext_en(1'b1), .ext_data(a_dat),
        .dev_out(a_out), .dev_oe_n(a_oe_n), .level(a_lvl));
    bus_side_model bus_b_u (.pclk(pclk), .ext_en(1'b1), .ext_data(b_dat),
        .dev_out(b_out), .dev_oe_n(b_oe_n), .level(b_lvl));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // waits for pready with no assumed latency; watchdog cuts a hang
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // pin held high two cycles so the sampled rise is never missed
    task automatic pulse(input logic ba);
        @(posedge pclk);
        if (ba) clk_b_to_a <= 1'b1; else clk_a_to_b <= 1'b1;
        repeat (2) @(posedge pclk);
        clk_b_to_a <= 1'b0;
        clk_a_to_b <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : pulse
    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask : settle
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, clk_a_to_b, clk_b_to_a} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        a_dat = 8'h3c;
        b_dat = 8'hc3;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFFS, 32'h0);
        chk(rd, 32'h1);
        chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
        apb(1'b0, STATUS_OFFS, 32'h0);
        chk(rd[1:0], 32'h0);
        pulse(1'b0);
        pulse(1'b1);
        a_dat <= 8'h99;
        pulse(1'b0);
        apb(1'b0, STATUS_OFFS, 32'h0);
        chk(rd[4:0], 32'h13);
        apb(1'b0, STORE_OFFS, 32'h0);
        chk(rd, 32'h8000003c);
        apb(1'b0, STORE_OFFS, 32'h0);
        chk(rd, 32'h8000c33c);
        apb(1'b0, STORE_OFFS, 32'h0);
        chk(rd[31], 32'h0);
        apb(1'b1, CTRL_OFFS, 32'h2);
        a_dat <= 8'h5a;
        settle();
        chk({a_oe_n, b_oe_n, b_out}, {22'h0, 2'b10, 8'h5a});
        a_dat <= 8'ha5;
        settle();
        chk(b_out, 32'ha5);
        apb(1'b1, CTRL_OFFS, 32'h6);
        settle();
        chk(b_out, 32'h99);
        apb(1'b1, CTRL_OFFS, 32'he);
        settle();
        chk(b_out, 32'h99);
        pulse(1'b0);
        settle();
        chk(b_out, 32'ha5);
        a_dat <= 8'h11;
        settle();
        chk(b_out, 32'ha5);
        apb(1'b1, CTRL_OFFS, 32'h0);
        b_dat <= 8'h77;
        settle();
        chk({a_oe_n, b_oe_n, a_out}, {22'h0, 2'b01, 8'h77});
        apb(1'b1, CTRL_OFFS, 32'h8);
        settle();
        chk(a_out, 32'hc3);
        apb(1'b1, CTRL_OFFS, 32'hc);
        settle();
        chk(a_out, 32'hc3);
        pulse(1'b1);
        settle();
        chk(a_out, 32'h77);
        apb(1'b1, CTRL_OFFS, 32'h3);
        settle();
        chk({30'h0, a_oe_n, b_oe_n}, 32'h3);
        apb(1'b1, STATUS_OFFS, 32'h0);
        chk({31'h0, er}, 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, CTRL_OFFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule : bus_transceiver_tb_top
`default_nettype wire
